/* File: sram_ctl_regs.svh */
// Constants for the single-cycle static memory control logic
`ifndef SRAM_CTL_REGS_SVH
`define SRAM_CTL_REGS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NUM_BANKS 4
`define BANK_W 2
`define ADDR_W 32
`define DATA_W 32

// ----------------------------------------
// Bank control access
// ----------------------------------------
`define BANK_CTRL_ADDR 32'hffff_fff0
`define DBANK_LSB 0
`define IBANK_LSB 2
`define BBANK_LSB 4
`define BRIDGE_BIT 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DBANK_RST 2'h0
`define IBANK_RST 2'h0
`define BBANK_RST 2'h1
`define BRIDGE_RST 1'h0

`endif

/* File: sram_ctl_pkg.sv */
// Types for the single-cycle static memory control logic
`include "sram_ctl_regs.svh"

package sram_ctl_pkg;

  typedef enum logic {PH_IDLE, PH_WAIT} phase_t;

  // Instruction bus request
  typedef struct packed {
    logic req;
    logic rd;
    logic [`ADDR_W-1:0] addr;
  } ibus_t;

  // Data bus request
  typedef struct packed {
    logic req;
    logic rd;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } dbus_t;

  // Whole state of the controller
  typedef struct packed {
    logic [`BANK_W-1:0] dbank;
    logic [`BANK_W-1:0] ibank;
    logic [`BANK_W-1:0] bbank;
    logic bridge;
    phase_t phase;
  } ctl_state_t;

endpackage : sram_ctl_pkg

/* File: bank_ce_gate.sv */
// Per-bank chip enable gating of the system clock
`timescale 1ns/1ps
`include "sram_ctl_regs.svh"

module bank_ce_gate
  import sram_ctl_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bank qualifiers
  input wire logic [`NUM_BANKS-1:0] en,
  // Active-low chip enables
  output logic [`NUM_BANKS-1:0] ce_n
);

  // Every bank passes one identical OR level; en moves only while clk is high
  genvar g;
  generate
    for (g = 0; g < `NUM_BANKS; g = g + 1)
    begin : g_bank
      assign ce_n[g] = clk | ~en[g];
    end
  endgenerate

endmodule : bank_ce_gate

/* File: single_cycle_sram_control.sv */
// Control logic for zero-wait single-cycle static memory banks
// Functional notes
// - Chip enable low only in second clock half
// - Never enable memory before read/write is valid
// - Chip enable taken straight from system clock
// - Write strobe gated by its space's request
// - Per-bank enables gated through equal levels
// - Bank selection registered, not decoded per cycle
// - Designated address write loads bank registers
// - Switch takes a cycle; next access uses it
// - Bridge mode deselects data banks, enables buffer
// - Bridged data accesses stretched to two cycles
// - Address and write enable settle before enable
`timescale 1ns/1ps
`include "sram_ctl_regs.svh"

module single_cycle_sram_control
  import sram_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Processor buses
  input wire ibus_t ibus,
  input wire dbus_t dbus,
  // System clock forwarded to memories
  output logic system_clock_out,
  // Chip enables per bank
  output logic [`NUM_BANKS-1:0] instr_ce_n,
  output logic [`NUM_BANKS-1:0] data_ce_n,
  // Write strobes per bank
  output logic [`NUM_BANKS-1:0] instr_we_n,
  output logic [`NUM_BANKS-1:0] data_we_n,
  // Instruction-to-data bridge buffer
  output logic bridge_oe,
  // Data bus response
  output logic data_ready_response_n
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ctl_state_t st_r;
  ctl_state_t st_nxt;

  logic ctrl_wr;
  logic bridge_acc;
  logic data_rdy;
  logic [`NUM_BANKS-1:0] data_en;
  logic [`NUM_BANKS-1:0] instr_en;

  // Write to the bank control address
  // Control writes never reach a memory bank
  assign ctrl_wr = dbus.req & ~dbus.rd & (dbus.addr == `BANK_CTRL_ADDR);
  assign bridge_acc = dbus.req & st_r.bridge & ~ctrl_wr;

  always_comb
  begin
    st_nxt = st_r;
    if (ctrl_wr)
    begin
      // Loaded at cycle end, so the following access sees it
      st_nxt.dbank = dbus.wdata[`DBANK_LSB +: `BANK_W];
      st_nxt.ibank = dbus.wdata[`IBANK_LSB +: `BANK_W];
      st_nxt.bbank = dbus.wdata[`BBANK_LSB +: `BANK_W];
      st_nxt.bridge = dbus.wdata[`BRIDGE_BIT];
    end
    case (st_r.phase)
      PH_IDLE:
      begin
        if (bridge_acc)
        begin
          st_nxt.phase = PH_WAIT;
        end
      end
      PH_WAIT:
      begin
        st_nxt.phase = PH_IDLE;
      end
      default:
      begin
        st_nxt.phase = PH_IDLE;
      end
    endcase
  end

  // Reset leaves default banks selected so fetches land somewhere valid
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r.dbank <= `DBANK_RST;
      st_r.ibank <= `IBANK_RST;
      st_r.bbank <= `BBANK_RST;
      st_r.bridge <= `BRIDGE_RST;
      st_r.phase <= PH_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Bank qualifiers and strobes
  // ----------------------------------------
  genvar b;
  generate
    for (b = 0; b < `NUM_BANKS; b = b + 1)
    begin : g_bank
      localparam int bank_idx = b;
      // Data banks all off in bridge mode or during a switch
      assign data_en[b] = ~st_r.bridge & ~ctrl_wr &
                          (st_r.dbank == bank_idx[`BANK_W-1:0]);
      assign instr_en[b] = (st_r.ibank == bank_idx[`BANK_W-1:0]) |
                           (bridge_acc & (st_r.bbank == bank_idx[`BANK_W-1:0]));
      // Strobes decoded while clk is high, before the enable opens
      assign data_we_n[b] = ~(data_en[b] & dbus.req & ~dbus.rd);
      assign instr_we_n[b] =
        ~((ibus.req & ~ibus.rd & (st_r.ibank == bank_idx[`BANK_W-1:0])) |
          (bridge_acc & ~dbus.rd & (st_r.bbank == bank_idx[`BANK_W-1:0])));
    end
  endgenerate

  // ----------------------------------------
  // Clock-derived enables
  // ----------------------------------------
  bank_ce_gate u_data_gate (
    .clk(clk),
    .en(data_en),
    .ce_n(data_ce_n)
  );

  bank_ce_gate u_instr_gate (
    .clk(clk),
    .en(instr_en),
    .ce_n(instr_ce_n)
  );

  // Forwarded ungated; any decode here would eat memory access time
  assign system_clock_out = clk;

  // ----------------------------------------
  // Responses
  // ----------------------------------------
  // Bridged accesses answer only in their second cycle
  assign data_rdy = dbus.req & (~bridge_acc | (st_r.phase == PH_WAIT));
  assign data_ready_response_n = ~data_rdy;
  // Buffer follows the registered mode only, never the bus
  assign bridge_oe = st_r.bridge;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_bank_load: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> (st_r.dbank == $past(dbus.wdata[`DBANK_LSB +: `BANK_W]))
      && (st_r.bridge == $past(dbus.wdata[`BRIDGE_BIT])))
    else $error("bank registers not loaded");

  a_sel_held: assert property (@(posedge clk) disable iff (rst)
    !ctrl_wr |=> $stable(st_r.dbank) && $stable(st_r.ibank))
    else $error("bank selection changed without control access");

  a_switch_next: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && !dbus.wdata[`BRIDGE_BIT] |=> ctrl_wr ||
      (data_en[$past(dbus.wdata[`DBANK_LSB +: `BANK_W])] && $onehot(data_en)))
    else $error("access after switch not on new bank");

  a_data_single: assert property (@(posedge clk) disable iff (rst)
    $onehot0(data_en))
    else $error("more than one data bank enabled");

  a_instr_sel: assert property (@(posedge clk) disable iff (rst)
    !bridge_acc |-> instr_en[st_r.ibank] && $onehot(instr_en))
    else $error("instruction bank enable not from selection");

  a_ctl_quiet: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |-> (data_en == '0) && (data_we_n == '1))
    else $error("control write reached a data bank");

  a_bridge_off: assert property (@(posedge clk) disable iff (rst)
    st_r.bridge |-> (data_en == '0) && bridge_oe)
    else $error("data bank enabled in bridge mode");

  a_bridge_wait: assert property (@(posedge clk) disable iff (rst)
    bridge_acc && st_r.phase == PH_IDLE |->
      data_ready_response_n ##1 (!bridge_acc || !data_ready_response_n))
    else $error("bridged access not stretched to two cycles");

  a_wait_once: assert property (@(posedge clk) disable iff (rst)
    st_r.phase == PH_WAIT |=> st_r.phase == PH_IDLE)
    else $error("bridged access held longer than two cycles");

  a_ready_plain: assert property (@(posedge clk) disable iff (rst)
    dbus.req && !bridge_acc |-> !data_ready_response_n)
    else $error("plain data access not answered at once");

  a_bridge_ce: assert property (@(posedge clk) disable iff (rst)
    bridge_acc |-> instr_en[st_r.bbank])
    else $error("bridged access did not enable bridge bank");

  a_data_we_gate: assert property (@(posedge clk) disable iff (rst)
    (data_we_n != '1) |-> dbus.req && !dbus.rd && !st_r.bridge)
    else $error("data write strobe without data request");

  a_instr_we_gate: assert property (@(posedge clk) disable iff (rst)
    (instr_we_n != '1) |-> (ibus.req && !ibus.rd) || (bridge_acc && !dbus.rd))
    else $error("instruction write strobe without request");

  a_reset_bank: assert property (@(posedge clk)
    rst |=> st_r.ibank == `IBANK_RST && st_r.dbank == `DBANK_RST && !st_r.bridge)
    else $error("reset did not select default banks");

  // ----------------------------------------
  // Covers
  // ----------------------------------------
  c_switch: cover property (@(posedge clk) disable iff (rst) ctrl_wr ##1 dbus.req);
  c_bridge_exit: cover property (@(posedge clk) disable iff (rst) st_r.bridge ##1 !st_r.bridge);
  c_bridge_rd: cover property (@(posedge clk) disable iff (rst)
    bridge_acc && dbus.rd ##1 !data_ready_response_n);
  c_bridge_wr: cover property (@(posedge clk) disable iff (rst) bridge_acc && !dbus.rd);
  c_instr_wr: cover property (@(posedge clk) disable iff (rst) ibus.req && !ibus.rd);

endmodule : single_cycle_sram_control

/* File: sram_proc_model.sv */
// Processor bus model for the static memory controller
`timescale 1ns/1ps

module sram_proc_model
  import sram_ctl_pkg::*;
(
  // Clock and response
  input wire logic clk,
  input wire logic ready_n,
  // Buses
  output ibus_t ibus,
  output dbus_t dbus
);
  initial
  begin
    ibus = '0;
    dbus = '0;
  end

  // Called at a falling edge; holds the request until ready, giving up after four tries
  task automatic dop(input ibus_t ib, input dbus_t db, output int n);
    ibus = ib;
    dbus = db;
    n = 0;
    while (n < 4)
    begin
      #45;
      n++;
      if (ready_n === 1'b0)
        break;
      @(negedge clk);
    end
    @(negedge clk);
  endtask : dop

  // Released lines show the inverse of their last value
  task automatic idle();
    ibus = '{1'b0, ~ibus.rd, ~ibus.addr};
    dbus = '{1'b0, ~dbus.rd, ~dbus.addr, ~dbus.wdata};
    @(negedge clk);
  endtask : idle

endmodule : sram_proc_model

/* File: single_cycle_sram_control_tb_top.sv */
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
`include "sram_ctl_regs.svh"

module single_cycle_sram_control_tb_top;
  import sram_ctl_pkg::*;

  typedef struct packed {
    logic [3:0] dce;
    logic [3:0] dwe;
    logic [1:0] ib;
    logic iwe;
    logic oe;
  } exp_t;

  logic clk;
  logic rst;
  ibus_t ibus;
  dbus_t dbus;
  logic system_clock_out;
  logic [3:0] instr_ce_n;
  logic [3:0] data_ce_n;
  logic [3:0] instr_we_n;
  logic [3:0] data_we_n;
  logic bridge_oe;
  logic data_ready_response_n;
  int num_errors = 0;
  int checked = 0;
  int i;
  exp_t q[$];
  exp_t e;
  logic [1:0] cur_db = `DBANK_RST;
  logic [1:0] cur_ib = `IBANK_RST;
  logic [1:0] cur_bb = `BBANK_RST;
  logic cur_oe = `BRIDGE_RST;

  single_cycle_sram_control u_single_cycle_sram_control (.clk(clk), .rst(rst), .ibus(ibus),
    .dbus(dbus), .system_clock_out(system_clock_out), .instr_ce_n(instr_ce_n),
    .data_ce_n(data_ce_n), .instr_we_n(instr_we_n), .data_we_n(data_we_n),
    .bridge_oe(bridge_oe), .data_ready_response_n(data_ready_response_n));

  sram_proc_model u_sram_proc_model (.clk(clk), .ready_n(data_ready_response_n),
    .ibus(ibus), .dbus(dbus));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp

  task automatic tally_and_finish();
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Enables stay off in the high half
  always @(posedge clk)
  begin
    #45;
    if (!rst)
    begin
      cmp("ce_high", {instr_ce_n, data_ce_n}, 8'hff);
      cmp("system_clock_out_high", system_clock_out, 1'b1);
    end
  end

  // Each ready takes the oldest expectation
  always @(negedge clk)
  begin
    #45;
    if (!rst && data_ready_response_n === 1'b0)
    begin
      e = q.pop_front();
      cmp("data_ce", data_ce_n, e.dce);
      cmp("data_we", data_we_n, e.dwe);
      cmp("instr_ce", instr_ce_n[e.ib], 1'b0);
      cmp("instr_we", instr_we_n[e.ib], e.iwe);
      cmp("bridge", bridge_oe, e.oe);
      cmp("system_clock_out_low", system_clock_out, 1'b0);
    end
  end

  task automatic go(input ibus_t ib, input dbus_t db, input exp_t x, input int nc);
    int n;
    q.push_back(x);
    u_sram_proc_model.dop(ib, db, n);
    cmp("cycles", n, nc);
    if (n > 3)
      tally_and_finish();
  endtask : go

  task automatic ctl(input logic [5:0] f, input logic br);
    go('{1'b1, 1'b1, 32'h44}, '{1'b1, 1'b0, `BANK_CTRL_ADDR, {25'h0, br, f}},
      '{4'hf, 4'hf, cur_ib, 1'b1, cur_oe}, 1);
    {cur_bb, cur_ib, cur_db} = f;
    cur_oe = br;
  endtask : ctl

  // Data read with an instruction write on the current banks
  task automatic norm();
    go('{1'b1, 1'b0, 32'h80}, '{1'b1, 1'b1, 32'h200, 32'h0},
      '{~(4'h1 << cur_db), 4'hf, cur_ib, 1'b0, 1'b0}, 1);
  endtask : norm

  initial
  begin
    rst = 1'b1;
    void'($urandom(85));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    go('{1'b1, 1'b1, 32'h40}, '{1'b1, 1'b0, 32'h100, $urandom},
      '{4'he, 4'he, 2'h0, 1'b1, 1'b0}, 1);
    for (i = 0; i < 4; i++)
    begin
      ctl(6'($urandom), 1'b0);
      norm();
    end
    ctl(6'($urandom), 1'b1);
    for (i = 0; i < 2; i++)
      go('{1'b0, 1'b1, 32'h0}, '{1'b1, i[0], 32'h300, $urandom},
        '{4'hf, 4'hf, cur_bb, i[0], 1'b1}, 2);
    ctl(6'($urandom), 1'b0);
    norm();
    u_sram_proc_model.idle();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    cur_db = `DBANK_RST;
    cur_ib = `IBANK_RST;
    cur_bb = `BBANK_RST;
    cur_oe = `BRIDGE_RST;
    norm();
    u_sram_proc_model.idle();
    cmp("queue", q.size(), 0);
    tally_and_finish();
  end

endmodule : single_cycle_sram_control_tb_top
